// [logic/hsm_capture.sv]
// file: capture register loaded on a rising strobe edge
`timescale 1ns/1ps
module hsm_capture #(
	parameter int unsigned W = 8
) (
	// clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	// strobe level and data to latch
	input  wire logic         strobe_i,
	input  wire logic [W-1:0] d_i,
	// latched data and one-cycle edge pulse
	output logic [W-1:0]      q_o,
	output logic              rise_o
);

	logic         strobe_q;
	logic [W-1:0] next_q;

	// data is held while the strobe is low, so take it at the end of the pulse
	always_comb begin
		rise_o = strobe_i & ~strobe_q;
		next_q = rise_o ? d_i : q_o;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			strobe_q <= 1'h1;
			q_o      <= '0;
		end else begin
			strobe_q <= strobe_i;
			q_o      <= next_q;
		end
	end

endmodule : hsm_capture

// [logic/hsm_pkg.sv]
// package: constants and carrier types for the host slave mailbox port
package hsm_pkg;

	// ==========================================================
	// status byte field positions
	localparam int unsigned STAT_OUT_EMPTY_BIT = 0;
	localparam int unsigned STAT_IN_FULL_BIT   = 1;
	localparam int unsigned STAT_CMD_TAG_BIT   = 2;
	localparam int unsigned STAT_PORT_EN_BIT   = 3;
	localparam int unsigned STAT_USER_LSB      = 4;
	localparam int unsigned STAT_USER_W        = 4;

	// ==========================================================
	// register select levels
	localparam logic SEL_DATA   = 1'h0;
	localparam logic SEL_STATUS = 1'h1;

	// ==========================================================
	// reset values
	localparam logic [7:0] DATA_RESET   = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h01; // output empty, port disabled
	localparam logic [2:0] SYNC_RESET   = 3'h7;  // strobes idle high

	// ==========================================================
	// host pin bundle as sampled
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic       register_select;
		logic [7:0] data;
	} hsm_host_s;

	// core side access request
	typedef struct packed {
		logic       rd_data;   // core read of host_to_core_data completes
		logic       wr_data;   // core write of core_to_host_data
		logic       wr_status; // core write of handshake_status
		logic [7:0] wdata;
	} hsm_core_req_s;

endpackage : hsm_pkg

// [logic/hsm_port.sv]
// file: top of the host slave mailbox port
`timescale 1ns/1ps
module hsm_port (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// host bus pins
	input  wire logic       cs_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic       register_select_i,
	input  wire logic [7:0] host_data_pins_i,
	output logic      [7:0] host_data_pins_o,
	output logic            host_data_pins_oe_o,
	// core side
	input  wire logic       core_rd_data_i,
	input  wire logic       core_wr_data_i,
	input  wire logic       core_wr_status_i,
	input  wire logic [7:0] core_wdata_i,
	output logic      [7:0] core_host_data_o,
	output logic      [7:0] core_status_o
);

	// ==========================================================
	// pin synchronisers
	hsm_pkg::hsm_host_s pin_s;
	logic               cs_n_s;
	logic               rd_n_s;
	logic               wr_n_s;
	logic               sel_s;
	hsm_pkg::hsm_core_req_s creq;

	// only control lines are synchronised; data is stable by the strobe edge
	// limitation: every host event is seen three to four clocks late, so a
	// strobe must stay low and high for at least five clocks to be caught
	hsm_sync #(.RESET_VAL(1'h1)) u_sync_cs (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (cs_n_i),
		.level_o   (cs_n_s)
	);
	hsm_sync #(.RESET_VAL(1'h1)) u_sync_rd (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (rd_n_i),
		.level_o   (rd_n_s)
	);
	hsm_sync #(.RESET_VAL(1'h1)) u_sync_wr (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (wr_n_i),
		.level_o   (wr_n_s)
	);
	hsm_sync #(.RESET_VAL(1'h0)) u_sync_sel (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.async_i   (register_select_i),
		.level_o   (sel_s)
	);

	// gather the qualified pins and core requests into carriers
	always_comb begin
		pin_s.cs_n            = cs_n_s;
		pin_s.rd_n            = rd_n_s;
		pin_s.wr_n            = wr_n_s;
		pin_s.register_select = sel_s;
		pin_s.data            = host_data_pins_i;
		creq.rd_data          = core_rd_data_i;
		creq.wr_data          = core_wr_data_i;
		creq.wr_status        = core_wr_status_i;
		creq.wdata            = core_wdata_i;
	end

	// ==========================================================
	// cycle tracking: hold the select seen while a strobe is low
	logic wr_act;
	logic rd_act;
	logic wr_sel;
	logic rd_sel;
	logic next_wr_act;
	logic next_rd_act;
	logic next_wr_sel;
	logic next_rd_sel;
	logic status_en;

	// cycles are only armed while selected and enabled; address may move at strobe end
	// a strobe that stays deselected or disabled until it rises never arms, so its end is ignored
	always_comb begin
		next_wr_act = wr_act;
		next_rd_act = rd_act;
		next_wr_sel = wr_sel;
		next_rd_sel = rd_sel;
		if (!pin_s.cs_n && !pin_s.wr_n && status_en) begin
			next_wr_act = 1'h1;
			next_wr_sel = pin_s.register_select;
		end else if (pin_s.wr_n) begin
			next_wr_act = 1'h0;
		end
		if (!pin_s.cs_n && !pin_s.rd_n && status_en) begin
			next_rd_act = 1'h1;
			next_rd_sel = pin_s.register_select;
		end else if (pin_s.rd_n) begin
			next_rd_act = 1'h0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wr_act <= 1'h0;
			rd_act <= 1'h0;
			wr_sel <= hsm_pkg::SEL_DATA;
			rd_sel <= hsm_pkg::SEL_DATA;
		end else begin
			wr_act <= next_wr_act;
			rd_act <= next_rd_act;
			wr_sel <= next_wr_sel;
			rd_sel <= next_rd_sel;
		end
	end

	// ==========================================================
	// host to core data register, latched on the write strobe rise
	logic       wr_rise;
	logic       wr_strobe;
	logic [7:0] host_to_core_data;

	// a raw strobe that ends outside an armed cycle is masked high
	always_comb begin
		wr_strobe = pin_s.wr_n | ~wr_act;
	end

	// select 0 or 1 both land here; the core's byte is untouched
	hsm_capture #(.W(8)) u_cap_wr (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.strobe_i  (wr_strobe),
		.d_i       (pin_s.data),
		.q_o       (host_to_core_data),
		.rise_o    (wr_rise)
	);

	// ==========================================================
	// host read completion edge
	logic rd_rise;
	logic rd_n_q;
	logic next_rd_n_q;

	// delayed copy of the qualified read strobe; resets to the idle level so
	// that leaving reset never looks like the end of a read
	always_comb begin
		next_rd_n_q = pin_s.rd_n;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rd_n_q <= 1'h1;
		end else begin
			rd_n_q <= next_rd_n_q;
		end
	end

	// end of a data read only; status reads have no side effect
	always_comb begin
		rd_rise = pin_s.rd_n & ~rd_n_q & rd_act & (rd_sel == hsm_pkg::SEL_DATA);
	end

	// ==========================================================
	// core to host data register
	logic [7:0] core_to_host_data;
	logic [7:0] next_core_to_host_data;

	// written only by the core
	// the host side never reaches this register, so no arbitration is needed
	always_comb begin
		next_core_to_host_data = creq.wr_data ? creq.wdata : core_to_host_data;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			core_to_host_data <= hsm_pkg::DATA_RESET;
		end else begin
			core_to_host_data <= next_core_to_host_data;
		end
	end

	// ==========================================================
	// handshake status register
	logic [7:0] handshake_status;
	logic [7:0] next_status;

	// core writes first; hardware events then win over any core write or clear
	// a late set keeps a flag from being lost to a core clear it raced with
	always_comb begin
		next_status = handshake_status;
		if (creq.wr_status) begin
			next_status = creq.wdata;
		end
		if (creq.rd_data) begin
			next_status[hsm_pkg::STAT_IN_FULL_BIT] = 1'h0;
		end
		if (creq.wr_data) begin
			next_status[hsm_pkg::STAT_OUT_EMPTY_BIT] = 1'h0;
		end
		if (wr_rise) begin
			next_status[hsm_pkg::STAT_IN_FULL_BIT] = 1'h1;
			next_status[hsm_pkg::STAT_CMD_TAG_BIT] = wr_sel;
		end
		if (rd_rise) begin
			next_status[hsm_pkg::STAT_OUT_EMPTY_BIT] = 1'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			handshake_status <= hsm_pkg::STATUS_RESET;
		end else begin
			handshake_status <= next_status;
		end
	end

	// ==========================================================
	// named status fields; the host view of the status byte is built from these, the core reads handshake_status directly
	logic [3:0] user_status;
	logic       port_enable;
	logic       command_tag;
	logic       input_full;
	logic       output_empty;

	// bit layout user[7:4], enable, tag, full, empty
	always_comb begin
		user_status  = handshake_status[hsm_pkg::STAT_USER_LSB +: hsm_pkg::STAT_USER_W];
		port_enable  = handshake_status[hsm_pkg::STAT_PORT_EN_BIT];
		command_tag  = handshake_status[hsm_pkg::STAT_CMD_TAG_BIT];
		input_full   = handshake_status[hsm_pkg::STAT_IN_FULL_BIT];
		output_empty = handshake_status[hsm_pkg::STAT_OUT_EMPTY_BIT];
	end

	// the enable gates arming and drive only; the core may still use the
	// registers while the host side is shut off
	always_comb begin
		status_en = port_enable;
	end

	// ==========================================================
	// host read data path
	logic [7:0] host_status_view;
	logic [7:0] next_pins;
	logic       next_oe;
	logic       raw_rd;

	// host sees output_full, the inverse of output_empty
	always_comb begin
		host_status_view = {user_status, port_enable, command_tag,
			input_full, ~output_empty};
	end

	// drive only while selected, reading and enabled; late by the sync delay
	// the pin value is registered so the pins never glitch between the two sources
	always_comb begin
		raw_rd    = ~pin_s.cs_n & ~pin_s.rd_n;
		next_oe   = raw_rd & status_en;
		next_pins = (pin_s.register_select == hsm_pkg::SEL_STATUS) ?
			host_status_view : core_to_host_data;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			host_data_pins_o    <= hsm_pkg::DATA_RESET;
			host_data_pins_oe_o <= 1'h0;
		end else begin
			host_data_pins_o    <= next_pins;
			host_data_pins_oe_o <= next_oe;
		end
	end

	// ==========================================================
	// core read view; the core checks the tag here before the data
	always_comb begin
		core_host_data_o = host_to_core_data;
		core_status_o    = handshake_status;
	end

endmodule : hsm_port

// [logic/hsm_sync.sv]
// file: three-stage synchroniser with agreement qualifier
`timescale 1ns/1ps
module hsm_sync #(
	parameter logic RESET_VAL = 1'h1
) (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	// async in, qualified out
	input  wire logic async_i,
	output logic      level_o
);

	logic [2:0] stage;
	logic [2:0] next_stage;
	logic       next_level;

	// shift, and accept a change only once stages two and three agree
	always_comb begin
		next_stage = {stage[1:0], async_i};
		next_level = (stage[1] == stage[2]) ? stage[2] : level_o;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			stage   <= {3{RESET_VAL}};
			level_o <= RESET_VAL;
		end else begin
			stage   <= next_stage;
			level_o <= next_level;
		end
	end

endmodule : hsm_sync

// [tb/hsm_host_model.sv]
// model: host processor running i/o cycles on the mailbox port
`timescale 1ns/1ps
module hsm_host_model (
	// clock
	input  wire logic       clk_sys_i,
	// resolved data bus
	input  wire logic [7:0] bus_i,
	// host pins
	output logic            cs_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic            sel_o,
	output logic [7:0]      data_o
);
	// strobe width and recovery, well above the five-clock minimum
	localparam int unsigned PULSE = 8;

	// ==========================================================
	// idle bus at time zero
	initial begin
		cs_n_o = 1'h1;
		rd_n_o = 1'h1;
		wr_n_o = 1'h1;
		sel_o  = 1'h0;
		data_o = 8'h00;
	end

	// one i/o cycle; data is held through recovery since capture follows the synced strobe
	task automatic host_cycle(input logic [9:0] a, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_sys_i);
		cs_n_o <= (a[9:1] != 9'h180); // only 300h/301h; no dma cycles issued
		sel_o  <= a[0];
		data_o <= wr ? d : ~data_o;
		wr_n_o <= !wr;
		rd_n_o <= wr;
		repeat (PULSE) @(posedge clk_sys_i);
		q = bus_i;
		wr_n_o <= 1'h1;
		rd_n_o <= 1'h1;
		cs_n_o <= 1'h1;
		repeat (PULSE) @(posedge clk_sys_i);
	endtask : host_cycle
endmodule : hsm_host_model

// [tb/hsm_port_sva.sv]
// checker: port-level properties of the host slave mailbox port
`timescale 1ns/1ps
module hsm_port_sva (
	// clock and reset
	input wire logic       clk_sys_i,
	input wire logic       rst_n_i,
	// host bus pins
	input wire logic       cs_n_i,
	input wire logic       rd_n_i,
	input wire logic       wr_n_i,
	input wire logic       register_select_i,
	input wire logic [7:0] host_data_pins_i,
	input wire logic [7:0] host_data_pins_o,
	input wire logic       host_data_pins_oe_o,
	// core side
	input wire logic       core_rd_data_i,
	input wire logic       core_wr_data_i,
	input wire logic       core_wr_status_i,
	input wire logic [7:0] core_wdata_i,
	input wire logic [7:0] core_host_data_o,
	input wire logic [7:0] core_status_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// ==========================================================
	// quiet strobe counters: core actions are judged only away from host events,
	// because a hardware set wins over a core clear in the same cycle
	logic [3:0] wr_hi_cnt;
	logic [3:0] rd_hi_cnt;
	logic [3:0] next_wr_hi_cnt;
	logic [3:0] next_rd_hi_cnt;
	always_comb begin
		next_wr_hi_cnt = !wr_n_i ? 4'h0 : wr_hi_cnt + {3'h0, wr_hi_cnt != 4'hf};
		next_rd_hi_cnt = !rd_n_i ? 4'h0 : rd_hi_cnt + {3'h0, rd_hi_cnt != 4'hf};
	end
	always_ff @(posedge clk_sys_i) begin
		wr_hi_cnt <= rst_n_i ? next_wr_hi_cnt : 4'h0;
		rd_hi_cnt <= rst_n_i ? next_rd_hi_cnt : 4'h0;
	end

	// ==========================================================
	// properties
	property p_oe_rise;
		$rose(host_data_pins_oe_o) |-> core_status_o[3] && !$past(cs_n_i, 2) && !$past(rd_n_i, 2);
	endproperty
	property p_oe_fall;
		$rose(rd_n_i) |-> ##[1:7] !host_data_pins_oe_o;
	endproperty
	property p_status_rd;
		host_data_pins_oe_o && $past(host_data_pins_oe_o) && register_select_i
			&& $stable(core_status_o) |-> host_data_pins_o == (core_status_o ^ 8'h01);
	endproperty
	sequence s_wr_end;
		$rose(wr_n_i) && !$past(cs_n_i) && core_status_o[3];
	endsequence
	property p_full_set;
		s_wr_end |-> ##[2:8] core_status_o[1];
	endproperty
	property p_tag;
		s_wr_end |-> ##[2:8] (core_status_o[2] == register_select_i);
	endproperty
	property p_full_clr;
		core_rd_data_i && wr_hi_cnt > 4'h7 |=> !core_status_o[1];
	endproperty
	property p_empty_clr;
		core_wr_data_i && rd_hi_cnt > 4'h7 |=> !core_status_o[0];
	endproperty
	property p_status_wr;
		core_wr_status_i && wr_hi_cnt > 4'h7 && rd_hi_cnt > 4'h7
			|=> core_status_o == $past(core_wdata_i);
	endproperty
	property p_data_moves;
		$changed(core_host_data_o) |-> core_status_o[1];
	endproperty

	a_oe_rise: assert property (p_oe_rise) else $error("drive began without a read");
	a_oe_fall: assert property (p_oe_fall) else $error("drive held after read");
	a_status_rd: assert property (p_status_rd) else $error("status byte wrong");
	a_full_set: assert property (p_full_set) else $error("input full not set");
	a_tag: assert property (p_tag) else $error("command tag wrong");
	a_full_clr: assert property (p_full_clr) else $error("input full not cleared");
	a_empty_clr: assert property (p_empty_clr) else $error("output empty stuck");
	a_status_wr: assert property (p_status_wr) else $error("status write lost");
	a_data_moves: assert property (p_data_moves) else $error("data moved alone");

	c_read: cover property ($rose(host_data_pins_oe_o));
	c_write: cover property ($rose(core_status_o[1]));
	c_both: cover property (core_wr_data_i && !wr_n_i);
endmodule : hsm_port_sva

bind hsm_port hsm_port_sva u_hsm_port_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .register_select_i(register_select_i),
	.host_data_pins_i(host_data_pins_i), .host_data_pins_o(host_data_pins_o),
	.host_data_pins_oe_o(host_data_pins_oe_o), .core_rd_data_i(core_rd_data_i),
	.core_wr_data_i(core_wr_data_i), .core_wr_status_i(core_wr_status_i),
	.core_wdata_i(core_wdata_i), .core_host_data_o(core_host_data_o),
	.core_status_o(core_status_o));

// [tb/hsm_port_test.sv]
// testbench: register-level scenarios for the host slave mailbox port
`timescale 1ns/1ps
module hsm_port_test;
	logic       clk_sys_i;
	logic       rst_n_i;
	logic       cs_n;
	logic       rd_n;
	logic       wr_n;
	logic       sel;
	logic [7:0] hdrv;
	logic [7:0] pins;
	logic       oe;
	logic [7:0] bus;
	logic       c_rd;
	logic       c_wr;
	logic       c_st;
	logic [7:0] c_wd;
	logic [7:0] c_data;
	logic [7:0] c_stat;
	logic [7:0] q;
	int         oe_hits;
	int         h;
	int         n_fail;
	int         n_tests;

	// resolved data bus: the port wins only while it drives
	assign bus = oe ? pins : hdrv;

	hsm_port u_hsm_port (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .register_select_i(sel), .host_data_pins_i(bus),
		.host_data_pins_o(pins), .host_data_pins_oe_o(oe), .core_rd_data_i(c_rd),
		.core_wr_data_i(c_wr), .core_wr_status_i(c_st), .core_wdata_i(c_wd),
		.core_host_data_o(c_data), .core_status_o(c_stat));
	hsm_host_model u_hsm_host_model (.clk_sys_i(clk_sys_i), .bus_i(bus), .cs_n_o(cs_n),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel), .data_o(hdrv));

	// ==========================================================
	// clock and drive counter
	initial begin
		clk_sys_i = 1'h0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) if (oe === 1'h1) oe_hits++;

	// ==========================================================
	// tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic regs(input logic [7:0] ed, input logic [7:0] es);
		chk("core data", ed, c_data);
		chk("core status", es, c_stat);
	endtask : regs
	// one-cycle core pulse, then two edges so the registered result has landed
	task automatic core(input logic rd, input logic wr, input logic st, input logic [7:0] d);
		@(posedge clk_sys_i);
		c_rd <= rd;
		c_wr <= wr;
		c_st <= st;
		c_wd <= d;
		@(posedge clk_sys_i);
		c_rd <= 1'h0;
		c_wr <= 1'h0;
		c_st <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
	endtask : core
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// ==========================================================
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		n_fail++;
		conclude();
	end

	// ==========================================================
	// main sequence
	initial begin
		rst_n_i = 1'h0;
		c_rd = 1'h0;
		c_wr = 1'h0;
		c_st = 1'h0;
		c_wd = 8'h00;
		n_fail = 0;
		n_tests = 0;
		oe_hits = 0;
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'h1;
		@(posedge clk_sys_i);
		regs(8'h00, 8'h01);
		chk("drive", 8'h00, {7'h0, oe});
		$display("test reset done");
		u_hsm_host_model.host_cycle(10'h300, 1'h1, 8'h5a, q);
		regs(8'h00, 8'h01);
		core(1'h0, 1'h0, 1'h1, 8'ha9);
		regs(8'h00, 8'ha9);
		u_hsm_host_model.host_cycle(10'h302, 1'h1, 8'h77, q);
		regs(8'h00, 8'ha9);
		$display("test enable done");
		u_hsm_host_model.host_cycle(10'h301, 1'h1, 8'h5a, q);
		regs(8'h5a, 8'haf);
		u_hsm_host_model.host_cycle(10'h301, 1'h0, 8'h00, q);
		chk("host status", 8'hae, q);
		core(1'h1, 1'h0, 1'h0, 8'h00);
		regs(8'h5a, 8'had);
		u_hsm_host_model.host_cycle(10'h300, 1'h1, 8'h3c, q);
		regs(8'h3c, 8'hab);
		core(1'h1, 1'h0, 1'h0, 8'h00);
		core(1'h0, 1'h1, 1'h0, 8'hc3);
		regs(8'h3c, 8'ha8);
		u_hsm_host_model.host_cycle(10'h301, 1'h0, 8'h00, q);
		chk("host status", 8'ha9, q);
		u_hsm_host_model.host_cycle(10'h300, 1'h0, 8'h00, q);
		chk("host data", 8'hc3, q);
		regs(8'h3c, 8'ha9);
		$display("test transaction done");
		fork
			u_hsm_host_model.host_cycle(10'h300, 1'h1, 8'h11, q);
			core(1'h0, 1'h1, 1'h0, 8'h22);
		join
		regs(8'h11, 8'haa);
		u_hsm_host_model.host_cycle(10'h300, 1'h0, 8'h00, q);
		chk("host data", 8'h22, q);
		$display("test overlap done");
		core(1'h0, 1'h0, 1'h1, 8'h01);
		h = oe_hits;
		u_hsm_host_model.host_cycle(10'h300, 1'h0, 8'h00, q);
		chk("drive count", 8'h00, 8'(oe_hits - h));
		$display("test disable done");
		conclude();
	end
endmodule : hsm_port_test
